// *** rtl/hpc_map.svh ***
// How it works
// - Config word at A4h, resets to zero
// - Bit 27 bypasses supply-voltage filter
// - Bits 10-9 pick idle tach level
// - Bits 8-7 pick fault tach level
// - Bit 6 enables alarm output pin
// - Bits 3-2 pick braking source
// - Bits 1-0 pick speed reference source
// - Freq mode: duty equals freq over full-scale
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HPC_PIN_CFG_OFF    12'h0a4
`define HPC_FULL_FREQ_OFF  12'h0b0
`define HPC_DIG_SPEED_OFF  12'h0b4
`define HPC_STATUS_OFF     12'h0b8

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define HPC_FILT_BIT       27
`define HPC_IDLE_LSB       9
`define HPC_FAULT_LSB      7
`define HPC_ALARM_BIT      6
`define HPC_BRAKE_LSB      2
`define HPC_SPEED_LSB      0
`define HPC_PIN_CFG_MASK   32'h080007cf
`define HPC_PIN_CFG_RST    32'h00000000
`define HPC_FULL_FREQ_RST  32'h00000000
`define HPC_DIG_SPEED_RST  32'h00000000

`endif

// *** rtl/hpc_pkg.sv ***
package hpc_pkg;
    // Speed reference source codes
    typedef enum logic [1:0] {
        HPC_SPD_ANALOG  = 2'h0,
        HPC_SPD_DUTY    = 2'h1,
        HPC_SPD_DIGITAL = 2'h2,
        HPC_SPD_FREQ    = 2'h3
    } hpc_speed_e;

    // Divider sequencing states, Gray along the path
    typedef enum logic [1:0] {
        HPC_DIV_IDLE = 2'b00,
        HPC_DIV_RUN  = 2'b01,
        HPC_DIV_DONE = 2'b11
    } hpc_div_e;
endpackage

// *** rtl/hpc_tach_sel.sv ***
`timescale 1ns/10ps
`include "hpc_map.svh"
// ----------------------------------------
// Tach output level selection
// ----------------------------------------
module hpc_tach_sel
    import hpc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [1:0] idle_sel,     // Idle level code
    input  wire logic [1:0] fault_sel,    // Fault level code
    input  wire logic       motor_run,    // Motor driving
    input  wire logic       motor_fault,  // Fault state
    input  wire logic       tach_raw,     // Core tach pulse
    output logic            tach_output   // Registered pin level
);
    logic last_run_r;  // Last level seen while driving

    // Track level while motor drives
    always_ff @(posedge clock) begin
        if (rst) begin
            last_run_r <= 1'b0;
        end else if (motor_run && !motor_fault) begin
            last_run_r <= tach_raw;
        end
    end

    // Fault has priority over idle
    always_ff @(posedge clock) begin
        if (rst) begin
            tach_output <= 1'b0;
        end else if (motor_fault) begin
            case (fault_sel)
                2'h1:    tach_output <= 1'b1;
                2'h2:    tach_output <= 1'b0;
                default: tach_output <= last_run_r; // Code 0 and undefined code 3: hold last driving level
            endcase
        end else if (!motor_run) begin
            case (idle_sel)
                2'h1, 2'h3: tach_output <= 1'b1;
                2'h2:       tach_output <= 1'b0;
                default:    tach_output <= tach_raw; // Core sets end state
            endcase
        end else begin
            tach_output <= tach_raw;
        end
    end

    a_tach_fault_hi: assert property (@(posedge clock) disable iff (rst)
        motor_fault && fault_sel == 2'h1 |=> tach_output)
        else $error("tach not high in fault");
    a_tach_idle_lo: assert property (@(posedge clock) disable iff (rst)
        !motor_fault && !motor_run && idle_sel == 2'h2 |=> !tach_output)
        else $error("tach not low when idle");
endmodule

// *** rtl/hpc_freq_div.sv ***
`timescale 1ns/10ps
`include "hpc_map.svh"
// ----------------------------------------
// Serial divider: duty = freq / full-scale
// ----------------------------------------
module hpc_freq_div
    import hpc_pkg::*;
#(
    parameter int W = 16  // Width of frequency and duty
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         start,      // Begin a division
    input  wire logic [W-1:0] freq_in,    // Measured frequency
    input  wire logic [W-1:0] full_freq,  // Full-scale frequency
    output logic      [W-1:0] duty,       // Fraction, all ones = 100%
    output logic              done        // One-cycle result pulse
);
    hpc_div_e         state_r;
    logic [W:0]       rem_r;     // Partial remainder
    logic [W-1:0]     quo_r;     // Quotient bits
    logic [$clog2(W+1)-1:0] cnt_r;
    logic [W:0]       trial;

    // Done lands W+2 edges after start is taken; one edge of slack below
    localparam int DONE_MIN = W + 1;  // Earliest done after start
    localparam int DONE_MAX = W + 2;  // Latest done after start

    // Restoring step, one bit per clock; trades speed for area
    always_comb begin
        trial = {rem_r[W-1:0], 1'b0} - {1'b0, full_freq};
    end

    // Sequencer and datapath
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= HPC_DIV_IDLE;
            rem_r   <= '0;
            quo_r   <= '0;
            cnt_r   <= '0;
            duty    <= '0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_r)
                HPC_DIV_IDLE: begin
                    if (start) begin
                        rem_r   <= {1'b0, freq_in};
                        quo_r   <= '0;
                        cnt_r   <= '0;
                        state_r <= HPC_DIV_RUN;
                    end
                end
                HPC_DIV_RUN: begin
                    if (!trial[W]) begin
                        rem_r <= trial;
                        quo_r <= {quo_r[W-2:0], 1'b1};
                    end else begin
                        rem_r <= {rem_r[W-1:0], 1'b0};
                        quo_r <= {quo_r[W-2:0], 1'b0};
                    end
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == ($clog2(W+1))'(W - 1)) begin
                        state_r <= HPC_DIV_DONE;
                    end
                end
                default: begin
                    // Saturate at or above full scale, or zero full scale
                    if (freq_in >= full_freq) begin
                        duty <= '1;
                    end else begin
                        duty <= quo_r;
                    end
                    done    <= 1'b1;
                    state_r <= HPC_DIV_IDLE;
                end
            endcase
        end
    end

    a_div_done_gap: assert property (@(posedge clock) disable iff (rst)
        start && state_r == HPC_DIV_IDLE |-> ##[DONE_MIN:DONE_MAX] done)
        else $error("divider result late");
endmodule

// *** rtl/hpc_pin_cfg.sv ***
`timescale 1ns/10ps
`include "hpc_map.svh"
// ----------------------------------------
// Hardware pin configuration register block
// ----------------------------------------
module hpc_pin_cfg
    import hpc_pkg::*;
#(
    parameter int FW = 16  // Frequency and duty width
) (
    input  wire logic          clock,
    input  wire logic          rst,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // Core side inputs
    input  wire logic          motor_run,
    input  wire logic          motor_fault,
    input  wire logic          tach_raw,
    input  wire logic          brake_pin,
    input  wire logic          alarm_event,
    input  wire logic [FW-1:0] speed_analog,
    input  wire logic [FW-1:0] speed_pwm_duty,
    input  wire logic [FW-1:0] speed_pin_freq,
    input  wire logic          speed_freq_valid,
    // Decoded outputs
    output logic               supply_filter_bypass,
    output logic               alarm_output,
    output logic               brake_apply,
    output logic [1:0]         speed_src,
    output logic [FW-1:0]      speed_cmd,
    output logic               tach_output
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [31:0]   pin_cfg_r;    // Configuration word
    logic [FW-1:0] full_freq_r;  // Full-scale frequency
    logic [FW-1:0] dig_speed_r;  // Host speed command
    logic [FW-1:0] freq_duty;    // Divider result
    logic          div_done;     // Divider done pulse
    logic          div_busy_r;   // Division in flight
    logic [FW-1:0] freq_duty_r;  // Latched frequency duty
    logic          access;       // APB access phase

    assign access = psel && penable;

    // Register writes; reserved bits masked
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_cfg_r   <= `HPC_PIN_CFG_RST;
            full_freq_r <= FW'(`HPC_FULL_FREQ_RST);
            dig_speed_r <= FW'(`HPC_DIG_SPEED_RST);
        end else if (access && pwrite) begin
            if (paddr == `HPC_PIN_CFG_OFF) begin
                pin_cfg_r <= pwdata & `HPC_PIN_CFG_MASK;
            end else if (paddr == `HPC_FULL_FREQ_OFF) begin
                full_freq_r <= pwdata[FW-1:0];
            end else if (paddr == `HPC_DIG_SPEED_OFF) begin
                dig_speed_r <= pwdata[FW-1:0];
            end
        end
    end

    // Read mux and slave answer, zero wait state
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && !penable) begin
                if (paddr == `HPC_PIN_CFG_OFF) begin
                    prdata <= pin_cfg_r;
                end else if (paddr == `HPC_FULL_FREQ_OFF) begin
                    prdata <= 32'(full_freq_r);
                end else if (paddr == `HPC_DIG_SPEED_OFF) begin
                    prdata <= 32'(dig_speed_r);
                end else if (paddr == `HPC_STATUS_OFF) begin
                    prdata <= {28'h0000000, tach_output, brake_apply,
                               alarm_output, div_busy_r};
                end else begin
                    pslverr <= 1'b1;  // Unmapped address
                end
            end
        end
    end

    // ----------------------------------------
    // Decoded controls
    // ----------------------------------------
    // Filter bypass straight from field
    always_ff @(posedge clock) begin
        if (rst) begin
            supply_filter_bypass <= 1'b0;
        end else begin
            supply_filter_bypass <= pin_cfg_r[`HPC_FILT_BIT];
        end
    end

    // Alarm pin only fires when enabled
    always_ff @(posedge clock) begin
        if (rst) begin
            alarm_output <= 1'b0;
        end else begin
            alarm_output <= pin_cfg_r[`HPC_ALARM_BIT] && alarm_event;
        end
    end

    // Brake source: pin, forced brake, or none
    always_ff @(posedge clock) begin
        if (rst) begin
            brake_apply <= 1'b0;
        end else begin
            case (pin_cfg_r[`HPC_BRAKE_LSB +: 2])
                2'h1:    brake_apply <= 1'b1;
                2'h2:    brake_apply <= 1'b0;
                default: brake_apply <= brake_pin;
            endcase
        end
    end

    // Kick the divider on a new frequency sample unless a division is in flight
    always_ff @(posedge clock) begin
        if (rst) begin
            div_busy_r  <= 1'b0;
            freq_duty_r <= '0;
        end else begin
            if (div_done) begin
                div_busy_r  <= 1'b0;
                freq_duty_r <= freq_duty;
            end else if (speed_freq_valid && !div_busy_r) begin
                div_busy_r <= 1'b1;
            end
        end
    end

    // Speed reference mux; digital mode ignores pin
    always_ff @(posedge clock) begin
        if (rst) begin
            speed_src <= 2'h0;
            speed_cmd <= '0;
        end else begin
            speed_src <= pin_cfg_r[`HPC_SPEED_LSB +: 2];
            case (hpc_speed_e'(pin_cfg_r[`HPC_SPEED_LSB +: 2]))
                HPC_SPD_ANALOG:  speed_cmd <= speed_analog;
                HPC_SPD_DUTY:    speed_cmd <= speed_pwm_duty;
                HPC_SPD_DIGITAL: speed_cmd <= dig_speed_r;
                default:         speed_cmd <= freq_duty_r;
            endcase
        end
    end

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    hpc_freq_div #(.W(FW)) u_div (
        .clock     (clock),
        .rst       (rst),
        .start     (speed_freq_valid && !div_busy_r),
        .freq_in   (speed_pin_freq),
        .full_freq (full_freq_r),
        .duty      (freq_duty),
        .done      (div_done)
    );

    hpc_tach_sel u_tach (
        .clock       (clock),
        .rst         (rst),
        .idle_sel    (pin_cfg_r[`HPC_IDLE_LSB +: 2]),
        .fault_sel   (pin_cfg_r[`HPC_FAULT_LSB +: 2]),
        .motor_run   (motor_run),
        .motor_fault (motor_fault),
        .tach_raw    (tach_raw),
        .tach_output (tach_output)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_cfg_write;
        access && pwrite && paddr == `HPC_PIN_CFG_OFF;
    endsequence

    // Setup phase of any transfer
    sequence s_setup;
        psel && !penable;
    endsequence

    a_rsvd_zero: assert property (@(posedge clock) disable iff (rst)
        (pin_cfg_r & ~`HPC_PIN_CFG_MASK) == 32'h0)
        else $error("reserved bit set");
    a_cfg_store: assert property (@(posedge clock) disable iff (rst)
        s_cfg_write |=> pin_cfg_r == ($past(pwdata) & `HPC_PIN_CFG_MASK))
        else $error("config write lost");
    a_filt_follow: assert property (@(posedge clock) disable iff (rst)
        s_cfg_write ##1 1'b1 |=> supply_filter_bypass == $past(pin_cfg_r[27]))
        else $error("filter bypass wrong");
    a_alarm_gate: assert property (@(posedge clock) disable iff (rst)
        !pin_cfg_r[6] |=> !alarm_output)
        else $error("alarm while disabled");
    a_brake_force: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_r[3:2] == 2'h1 |=> brake_apply)
        else $error("brake not forced");
    a_brake_pin: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) && pin_cfg_r[3:2] == 2'h0 |=> brake_apply == $past(brake_pin))
        else $error("brake not following pin");
    a_speed_dig: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_r[1:0] == 2'h2 |=> speed_cmd == $past(dig_speed_r))
        else $error("digital speed not used");
    a_speed_ana: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) && pin_cfg_r[1:0] == 2'h0 |=> speed_cmd == $past(speed_analog))
        else $error("analog speed not used");
    // Code-0 pin-following checks above skip the release edge: flops still see reset there

    // Bus answer timing and read data
    a_ready_pulse: assert property (@(posedge clock) disable iff (rst)
        s_setup |=> pready)
        else $error("ready missing after setup");

    a_ready_once: assert property (@(posedge clock) disable iff (rst)
        pready |=> !pready)
        else $error("ready held too long");

    a_err_ready: assert property (@(posedge clock) disable iff (rst)
        pslverr |-> pready)
        else $error("error without ready");

    a_cfg_read: assert property (@(posedge clock) disable iff (rst)
        s_setup ##0 (!pwrite && paddr == `HPC_PIN_CFG_OFF) |=> prdata == $past(pin_cfg_r))
        else $error("config read wrong");

    // Config only moves on its own write
    a_cfg_hold: assert property (@(posedge clock) disable iff (rst)
        !(access && pwrite && paddr == `HPC_PIN_CFG_OFF) |=> $stable(pin_cfg_r))
        else $error("config changed without write");

    // Remaining decode codes
    a_brake_none: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_r[3:2] == 2'h2 |=> !brake_apply)
        else $error("brake applied when overridden off");

    a_brake_pin3: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_r[3:2] == 2'h3 |=> brake_apply == $past(brake_pin))
        else $error("brake code 3 not following pin");

    a_alarm_follow: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_r[6] |=> alarm_output == $past(alarm_event))
        else $error("enabled alarm not following event");

    a_speed_duty: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_r[1:0] == 2'h1 |=> speed_cmd == $past(speed_pwm_duty))
        else $error("duty speed not used");

    a_speed_freq: assert property (@(posedge clock) disable iff (rst)
        pin_cfg_r[1:0] == 2'h3 |=> speed_cmd == $past(freq_duty_r))
        else $error("frequency speed not used");

    a_duty_latch: assert property (@(posedge clock) disable iff (rst)
        div_done |=> freq_duty_r == $past(freq_duty))
        else $error("divider result not latched");
endmodule

// *** test/hpc_host_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Host model: APB master issuing transfers
// ----------------------------------------
module hpc_host_model (
    input  wire logic        clock,    // System clock
    output logic             psel,     // Slave select
    output logic             penable,  // Access phase
    output logic             pwrite,   // Direction, high writes
    output logic      [11:0] paddr,    // Byte address
    output logic      [31:0] pwdata,   // Write data
    input  wire logic        pready    // Slave answer
);
    // Bus idle from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    // One transfer; ok stays low if the slave never answers
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Request held until ready is seen at an edge
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge clock);
            ok = (pready === 1'b1);
        end
        // Released lines show the inverse, so a stale copy cannot pass
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
`include "hpc_map.svh"
module tb_top
    import hpc_pkg::*;
;
    // ----------------------------------------
    // Clock, reset, bus and core wires
    // ----------------------------------------
    logic        clock = 1'b0;  // 250 MHz
    logic        rst   = 1'b1;  // Sync, active high
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        motor_run = 1'b0, motor_fault = 1'b0, tach_raw = 1'b0, brake_pin = 1'b0;
    logic        alarm_event = 1'b0, speed_freq_valid = 1'b0;
    logic [15:0] speed_analog = 16'h0000, speed_pwm_duty = 16'h0000, speed_pin_freq = 16'h0000;
    logic        supply_filter_bypass, alarm_output, brake_apply, tach_output;
    logic [1:0]  speed_src;
    logic [15:0] speed_cmd;
    int          n_errors = 0;   // Mismatches seen
    int          n_checks = 0;   // Comparisons made
    int          seed     = 58;  // Fixed random seed
    typedef struct packed {logic rd; logic [31:0] data; logic err;} hpc_exp_s;
    hpc_exp_s    exp_q[$];       // Expected bus answers, oldest first
    hpc_exp_s    mon_e;          // Note taken by the monitor

    always #2 clock = ~clock;

    hpc_host_model host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready));

    hpc_pin_cfg #(.FW(16)) dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .motor_run(motor_run), .motor_fault(motor_fault),
        .tach_raw(tach_raw), .brake_pin(brake_pin), .alarm_event(alarm_event),
        .speed_analog(speed_analog), .speed_pwm_duty(speed_pwm_duty),
        .speed_pin_freq(speed_pin_freq), .speed_freq_valid(speed_freq_valid),
        .supply_filter_bypass(supply_filter_bypass), .alarm_output(alarm_output),
        .brake_apply(brake_apply), .speed_src(speed_src), .speed_cmd(speed_cmd),
        .tach_output(tach_output));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic bad(input string m);
        n_errors++;
        $display("BAD %0t %s", $time, m);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
            n_errors++;
        end
    endtask

    // Single exit point; unanswered notes count against the run
    task automatic tally_and_finish();
        if (exp_q.size() != 0) begin
            bad("bus answers missing");
        end
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Bus helpers
    // ----------------------------------------
    // Note the expected answer, then run the transfer
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        bit ok;
        exp_q.push_back({~w, ed, ee});
        host.xfer(w, a, d, ok);
        if (!ok) begin
            bad("no ready");
            tally_and_finish();
        end
    endtask

    // Decoded outputs lag the write by one edge; three gives margin
    task automatic settle();
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic wcfg(input logic [31:0] v);
        bus(1'b1, `HPC_PIN_CFG_OFF, v, 32'h0, 1'b0);
        settle();
    endtask

    function automatic logic [31:0] cfg(input logic [1:0] idl, input logic [1:0] flt,
                                        input logic [1:0] sp);
        return {21'h0, idl, flt, 5'h0, sp};
    endfunction

    // Divider done lands W+2 edges after start; poll with a bound rather than count
    task automatic wait_cmd(input logic [15:0] e);
        int n;
        for (n = 0; n < 60 && speed_cmd !== e; n++) @(negedge clock);
        check(32'(speed_cmd), 32'(e), "freq duty");
    endtask

    // ----------------------------------------
    // Monitor: compare each answer with the oldest note
    // ----------------------------------------
    always @(posedge clock) begin
        if (!rst && psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                bad("unexpected answer");
            end else begin
                mon_e = exp_q.pop_front();
                check(32'(pslverr), 32'(mon_e.err), "slave error");
                if (mon_e.rd) check(prdata, mon_e.data, "read data");
            end
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int          i;
        logic [31:0] v, r;
        logic        brk;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check({26'h0, supply_filter_bypass, alarm_output, brake_apply, tach_output, speed_src},
              32'h0, "outputs at reset");
        bus(1'b0, `HPC_PIN_CFG_OFF, 32'h0, 32'h0, 1'b0);
        bus(1'b1, `HPC_PIN_CFG_OFF, 32'hffffffff, 32'h0, 1'b0);
        bus(1'b0, `HPC_PIN_CFG_OFF, 32'h0, `HPC_PIN_CFG_MASK, 1'b0);
        $display("test reset_and_mask done");
        // Random words, every brake and speed code
        for (i = 0; i < 16; i++) begin
            v = $random(seed);
            v[3:0] = {i[1:0], i[3:2]};
            r = $random(seed);
            @(posedge clock);
            brake_pin      <= r[0];
            alarm_event    <= r[1];
            speed_analog   <= r[17:2];
            speed_pwm_duty <= r[31:16];
            wcfg(v);
            bus(1'b0, `HPC_PIN_CFG_OFF, 32'h0, v & `HPC_PIN_CFG_MASK, 1'b0);
            @(negedge clock);
            brk = (v[3:2] == 2'h1) ? 1'b1 : (v[3:2] == 2'h2) ? 1'b0 : r[0];
            check(32'(supply_filter_bypass), 32'(v[27]), "filter bypass");
            check(32'(alarm_output), 32'(v[6] & r[1]), "alarm");
            check(32'(brake_apply), 32'(brk), "brake");
            check(32'(speed_src), 32'(v[1:0]), "speed source");
            if (v[1:0] == HPC_SPD_ANALOG) check(32'(speed_cmd), 32'(r[17:2]), "analog");
            if (v[1:0] == HPC_SPD_DUTY) check(32'(speed_cmd), 32'(r[31:16]), "duty");
        end
        $display("test fields done");
        // Digital source: host word wins, pin activity ignored
        r = $random(seed);
        bus(1'b1, `HPC_DIG_SPEED_OFF, r, 32'h0, 1'b0);
        bus(1'b0, `HPC_DIG_SPEED_OFF, 32'h0, {16'h0, r[15:0]}, 1'b0);
        wcfg(cfg(2'h0, 2'h0, HPC_SPD_DIGITAL));
        @(posedge clock);
        speed_analog   <= ~r[15:0];
        speed_pwm_duty <= ~r[15:0];
        settle();
        check(32'(speed_cmd), 32'(r[15:0]), "digital");
        // Frequency source: half scale, then past full scale
        bus(1'b1, `HPC_FULL_FREQ_OFF, 32'h8000, 32'h0, 1'b0);
        wcfg(cfg(2'h0, 2'h0, HPC_SPD_FREQ));
        for (i = 0; i < 2; i++) begin
            @(posedge clock);
            speed_pin_freq   <= i ? 16'h9000 : 16'h4000;
            speed_freq_valid <= 1'b1;
            @(posedge clock);
            speed_freq_valid <= 1'b0;
            wait_cmd(i ? 16'hffff : 16'h8000);
        end
        $display("test speed sources done");
        // Idle levels; raw level chosen opposite to any forced one
        for (i = 0; i < 4; i++) begin
            wcfg(cfg(i[1:0], 2'h0, 2'h0));
            @(posedge clock);
            tach_raw <= ~i[0];
            settle();
            check(32'(tach_output), 32'(i != 2), "idle tach");
        end
        // Fault levels; raw flips when the fault begins
        for (i = 0; i < 4; i++) begin
            wcfg(cfg(2'h0, i[1:0], 2'h0));
            @(posedge clock);
            motor_run <= 1'b1;
            tach_raw  <= ~i[0];
            settle();
            @(posedge clock);
            motor_run   <= 1'b0;
            motor_fault <= 1'b1;
            tach_raw    <= i[0];
            settle();
            check(32'(tach_output), 32'(i < 2), "fault tach");
            @(posedge clock);
            motor_fault <= 1'b0;
        end
        $display("test tach done");
        // Unmapped place refused, read-only status quiet
        bus(1'b1, 12'h0f0, 32'hffffffff, 32'h0, 1'b1);
        bus(1'b0, 12'h0f0, 32'h0, 32'h0, 1'b1);
        bus(1'b1, `HPC_STATUS_OFF, 32'hffffffff, 32'h0, 1'b0);
        // Idle code 0 passes raw tach, brake code 0 follows pin, alarm off
        bus(1'b0, `HPC_STATUS_OFF, 32'h0, {28'h0, tach_raw, brake_pin, 2'h0}, 1'b0);
        // Second reset clears the written word
        wcfg(32'hffffffff);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, `HPC_PIN_CFG_OFF, 32'h0, 32'h0, 1'b0);
        $display("test refusal_and_reset done");
        settle();
        tally_and_finish();
    end
endmodule
